// ===== design/qup_map.svh
// constants for the single-channel serial block: offsets, fields, resets, timing
// assumes one 10 MHz clock and a byte-wide register port with three address bits
`ifndef QUP_MAP_SVH
`define QUP_MAP_SVH
`define QUP_ADDR_DATA      3'h0
`define QUP_ADDR_LINE_CTL  3'h1
`define QUP_ADDR_DIV_LO    3'h2
`define QUP_ADDR_DIV_HI    3'h3
`define QUP_ADDR_MODEM_CTL 3'h4
`define QUP_ADDR_STATUS    3'h5
`define QUP_ADDR_FLOW_THR  3'h6
`define QUP_ADDR_READY_SUM 3'h7
`define QUP_LCR_LEN_LSB    0
`define QUP_LCR_STOP_BIT   2
`define QUP_LCR_PAR_EN     3
`define QUP_LCR_PAR_EVEN   4
`define QUP_MODEM_LOOP_BIT 4
`define QUP_MODEM_PRESC_BIT 7
`define QUP_LCR_RESET      8'h03
`define QUP_FLOW_RESET     8'h84
`define QUP_DIV_RESET      16'h0001
`define QUP_PRESC_RATIO    2'h3
`define QUP_FIFO_DEPTH     64
`define QUP_IDLE_CHARS     4
`endif

// ===== design/qup_pkg.sv
// types for the serial block
// assumes qup_map.svh supplies the numeric constants
package qup_pkg;
  typedef enum logic [2:0] {QUP_TX_IDLE, QUP_TX_START, QUP_TX_DATA, QUP_TX_PAR,
                            QUP_TX_STOP} qup_tx_state_t;
  typedef enum logic [2:0] {QUP_RX_IDLE, QUP_RX_START, QUP_RX_DATA, QUP_RX_PAR,
                            QUP_RX_STOP} qup_rx_state_t;
endpackage

// ===== design/qup_fifo.sv
// parameterised first-in first-out queue in flip-flops
// assumes one clock domain, valid/ready on both sides
`timescale 1ns/10ps
module qup_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // fill level
  output logic [AW:0]           level
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg < (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_reg];
  assign level     = cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // qup_fifo

// ===== design/qup_sync.sv
// two-flip-flop synchroniser for a pin level
// assumes the input is asynchronous to sys_clk
`timescale 1ns/10ps
module qup_sync #(
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // level
  input  wire logic pin,
  output logic      level
);
  logic meta_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      level    <= INIT;
    end else begin
      meta_reg <= pin;
      level    <= meta_reg;
    end
  end
endmodule // qup_sync

// ===== design/qup_uart.sv
// one serial channel: register port, prescaler, divisor, framing, queues
// assumes host strobes are asynchronous and held at least three sys_clk cycles
`timescale 1ns/10ps
`include "qup_map.svh"
module qup_uart (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // strap
  input  wire logic       prescaler_select_input,
  // register port
  input  wire logic       channel_select_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [2:0] register_address,
  input  wire logic [7:0] data_bus_in,
  output logic      [7:0] data_bus_out,
  output logic            data_bus_oe_n,
  // other channels' ready flags for the summary register
  input  wire logic [2:0] peer_transmit_ready,
  input  wire logic [2:0] peer_receive_ready,
  // serial line and modem
  output logic            serial_out,
  input  wire logic       serial_in,
  input  wire logic       carrier_detect_n,
  output logic            request_to_send_n,
  // status
  output logic            transmit_ready_flag,
  output logic            receive_ready_flag,
  output logic            rx_threshold_irq,
  output logic            tx_threshold_irq,
  output logic            carrier_present
);
  logic       cs_s, rd_s, wr_s, rx_s, sel_s, carrier_present_n_s;
  logic       rd_d_reg, rd_dd_reg, wr_d_reg;
  logic       rd_pulse, wr_pulse;
  logic [2:0] addr_reg;
  logic [7:0] wdat_reg;
  logic [7:0] line_ctl_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] flow_threshold_reg;
  logic [15:0] divisor_reg;
  logic       strap_pending_reg;
  logic [1:0] presc_reg;
  logic       presc_tick;
  logic [15:0] div_reg;
  logic       bit_tick;
  logic [3:0] os_reg;
  logic       os_tick;
  logic [2:0] char_len;
  logic       tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready;
  logic [7:0] tx_out_data;
  logic [6:0] tx_level, rx_level;
  logic       rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready;
  logic [7:0] rx_out_data;
  qup_pkg::qup_tx_state_t tx_state_reg;
  qup_pkg::qup_rx_state_t rx_state_reg;
  logic [7:0] tx_sh_reg;
  logic [2:0] tx_cnt_reg;
  logic [4:0] tx_os_reg;
  logic       tx_par_reg;
  logic       tx_started_reg;
  logic [7:0] rx_sh_reg;
  logic [2:0] rx_cnt_reg;
  logic [3:0] rx_os_reg;
  logic       rx_par_reg;
  logic       rx_line;
  logic [5:0] idle_reg;
  logic       err_break_reg, err_idle_reg, err_frame_reg;
  logic       err_over_reg, err_par_reg, err_under_reg;
  logic       status_rd;

  qup_sync #(.INIT(1'b1)) u_cs  (.sys_clk(sys_clk), .rst_n(rst_n), .pin(channel_select_n),
                                 .level(cs_s));
  qup_sync #(.INIT(1'b1)) u_rd  (.sys_clk(sys_clk), .rst_n(rst_n), .pin(read_strobe_n),
                                 .level(rd_s));
  qup_sync #(.INIT(1'b1)) u_wr  (.sys_clk(sys_clk), .rst_n(rst_n), .pin(write_strobe_n),
                                 .level(wr_s));
  qup_sync #(.INIT(1'b1)) u_rx  (.sys_clk(sys_clk), .rst_n(rst_n), .pin(serial_in),
                                 .level(rx_s));
  // strap synchroniser keeps sampling through reset so release sees the pin
  qup_sync #(.INIT(1'b1)) u_sel (.sys_clk(sys_clk), .rst_n(1'b1),
                                 .pin(prescaler_select_input), .level(sel_s));
  qup_sync #(.INIT(1'b1)) u_cd  (.sys_clk(sys_clk), .rst_n(rst_n), .pin(carrier_detect_n),
                                 .level(carrier_present_n_s));

  // strobe edges, address and data sampled while the channel is selected
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_d_reg  <= 1'b1;
      rd_dd_reg <= 1'b1;
      wr_d_reg  <= 1'b1;
    end else begin
      rd_d_reg  <= rd_s | cs_s;
      rd_dd_reg <= rd_d_reg;
      wr_d_reg <= wr_s | cs_s;
    end
  end

  // read acts one cycle late so addr_reg already holds this access's address
  assign rd_pulse = rd_dd_reg && !rd_d_reg;
  assign wr_pulse = !wr_d_reg && (wr_s | cs_s);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 3'h0;
      wdat_reg <= 8'h00;
    end else if (!cs_s) begin
      addr_reg <= register_address;
      wdat_reg <= data_bus_in;
    end
  end

  // register writes; the prescaler bit is loaded from the strap after release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_ctl_reg       <= `QUP_LCR_RESET;
      modem_control_reg  <= 8'h00;
      flow_threshold_reg <= `QUP_FLOW_RESET;
      divisor_reg        <= `QUP_DIV_RESET;
      strap_pending_reg  <= 1'b1;
    end else begin
      strap_pending_reg <= 1'b0;
      if (strap_pending_reg) begin
        modem_control_reg[`QUP_MODEM_PRESC_BIT] <= ~sel_s;
      end
      if (wr_pulse) begin
        case (addr_reg)
          `QUP_ADDR_LINE_CTL:  line_ctl_reg       <= wdat_reg;
          `QUP_ADDR_DIV_LO:    divisor_reg[7:0]   <= wdat_reg;
          `QUP_ADDR_DIV_HI:    divisor_reg[15:8]  <= wdat_reg;
          `QUP_ADDR_MODEM_CTL: modem_control_reg  <= wdat_reg;
          `QUP_ADDR_FLOW_THR:  flow_threshold_reg <= wdat_reg;
          default: ;
        endcase
      end
    end
  end

  // prescaler then divisor then sixteen-times oversample
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= 2'h0;
    end else if (modem_control_reg[`QUP_MODEM_PRESC_BIT]) begin
      presc_reg <= presc_tick ? 2'h0 : presc_reg + 2'h1;
    end else begin
      presc_reg <= 2'h0;
    end
  end

  assign presc_tick = !modem_control_reg[`QUP_MODEM_PRESC_BIT] ||
                      (presc_reg == `QUP_PRESC_RATIO);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 16'h0001;
    end else if (presc_tick) begin
      div_reg <= (div_reg <= 16'h0001) ? divisor_reg : div_reg - 16'h0001;
    end
  end

  assign bit_tick = presc_tick && (div_reg <= 16'h0001) && (divisor_reg != 16'h0000);
  assign os_tick  = bit_tick;
  assign char_len = 3'(5 + line_ctl_reg[1:0]);

  // transmit queue
  assign tx_in_valid = wr_pulse && (addr_reg == `QUP_ADDR_DATA);
  qup_fifo #(.WIDTH(8), .DEPTH(`QUP_FIFO_DEPTH), .AW(6)) u_tx_fifo (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .in_valid(tx_in_valid), .in_ready(tx_in_ready), .in_data(wdat_reg),
    .out_valid(tx_out_valid), .out_ready(tx_out_ready), .out_data(tx_out_data),
    .level(tx_level));

  assign tx_out_ready = (tx_state_reg == qup_pkg::QUP_TX_IDLE) && os_tick &&
                        (tx_os_reg == 5'h0);

  // transmitter, one sixteenth-bit step per os_tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= qup_pkg::QUP_TX_IDLE;
      tx_sh_reg    <= 8'h00;
      tx_cnt_reg   <= 3'h0;
      tx_os_reg    <= 5'h0;
      tx_par_reg   <= 1'b0;
      serial_out   <= 1'b1;
    end else if (os_tick) begin
      tx_os_reg <= (tx_os_reg == 5'h0) ? 5'h0 : tx_os_reg - 5'h1;
      case (tx_state_reg)
        qup_pkg::QUP_TX_IDLE: begin
          serial_out <= 1'b1;
          if (tx_out_valid) begin
            tx_sh_reg    <= tx_out_data;
            tx_par_reg   <= ~line_ctl_reg[`QUP_LCR_PAR_EVEN];
            serial_out   <= 1'b0;
            tx_os_reg    <= 5'hf;
            tx_state_reg <= qup_pkg::QUP_TX_START;
          end
        end
        qup_pkg::QUP_TX_START, qup_pkg::QUP_TX_DATA: begin
          if (tx_os_reg == 5'h0) begin
            if (tx_state_reg == qup_pkg::QUP_TX_DATA && tx_cnt_reg == char_len - 3'h1) begin
              tx_state_reg <= line_ctl_reg[`QUP_LCR_PAR_EN] ? qup_pkg::QUP_TX_PAR
                                                           : qup_pkg::QUP_TX_STOP;
              serial_out   <= line_ctl_reg[`QUP_LCR_PAR_EN] ? tx_par_reg : 1'b1;
              tx_os_reg    <= line_ctl_reg[`QUP_LCR_PAR_EN] ? 5'hf :
                              (line_ctl_reg[`QUP_LCR_STOP_BIT] ?
                               (line_ctl_reg[1:0] == 2'h0 ? 5'h17 : 5'h1f) : 5'hf);
            end else begin
              tx_cnt_reg   <= (tx_state_reg == qup_pkg::QUP_TX_START) ? 3'h0 : tx_cnt_reg + 3'h1;
              serial_out   <= tx_sh_reg[0];
              tx_par_reg   <= tx_par_reg ^ tx_sh_reg[0];
              tx_sh_reg    <= {1'b0, tx_sh_reg[7:1]};
              tx_os_reg    <= 5'hf;
              tx_state_reg <= qup_pkg::QUP_TX_DATA;
            end
          end
        end
        qup_pkg::QUP_TX_PAR: begin
          if (tx_os_reg == 5'h0) begin
            serial_out   <= 1'b1;
            tx_os_reg    <= line_ctl_reg[`QUP_LCR_STOP_BIT] ?
                            (line_ctl_reg[1:0] == 2'h0 ? 5'h17 : 5'h1f) : 5'hf;
            tx_state_reg <= qup_pkg::QUP_TX_STOP;
          end
        end
        qup_pkg::QUP_TX_STOP: begin
          if (tx_os_reg == 5'h0) begin
            tx_state_reg <= qup_pkg::QUP_TX_IDLE;
          end
        end
        default: tx_state_reg <= qup_pkg::QUP_TX_IDLE;
      endcase
    end
  end

  // receive line, looped back from the transmitter when asked
  assign rx_line = modem_control_reg[`QUP_MODEM_LOOP_BIT] ? serial_out : rx_s;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= qup_pkg::QUP_RX_IDLE;
      rx_sh_reg    <= 8'h00;
      rx_cnt_reg   <= 3'h0;
      rx_os_reg    <= 4'h0;
      rx_par_reg   <= 1'b0;
    end else if (os_tick) begin
      rx_os_reg <= rx_os_reg - 4'h1;
      case (rx_state_reg)
        qup_pkg::QUP_RX_IDLE: begin
          if (!rx_line) begin
            rx_os_reg    <= 4'h7;
            rx_state_reg <= qup_pkg::QUP_RX_START;
          end
        end
        qup_pkg::QUP_RX_START: begin
          if (rx_os_reg == 4'h0) begin
            rx_state_reg <= rx_line ? qup_pkg::QUP_RX_IDLE : qup_pkg::QUP_RX_DATA;
            rx_cnt_reg   <= 3'h0;
            rx_par_reg   <= ~line_ctl_reg[`QUP_LCR_PAR_EVEN];
            rx_os_reg    <= 4'hf;
          end
        end
        qup_pkg::QUP_RX_DATA: begin
          if (rx_os_reg == 4'h0) begin
            rx_sh_reg  <= {rx_line, rx_sh_reg[7:1]};
            rx_par_reg <= rx_par_reg ^ rx_line;
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == char_len - 3'h1) begin
              rx_state_reg <= line_ctl_reg[`QUP_LCR_PAR_EN] ? qup_pkg::QUP_RX_PAR
                                                           : qup_pkg::QUP_RX_STOP;
            end
          end
        end
        qup_pkg::QUP_RX_PAR: begin
          if (rx_os_reg == 4'h0) begin
            rx_par_reg   <= rx_par_reg ^ rx_line;
            rx_state_reg <= qup_pkg::QUP_RX_STOP;
          end
        end
        qup_pkg::QUP_RX_STOP: begin
          if (rx_os_reg == 4'h0) begin
            rx_state_reg <= qup_pkg::QUP_RX_IDLE;
          end
        end
        default: rx_state_reg <= qup_pkg::QUP_RX_IDLE;
      endcase
    end
  end

  // received byte aligned so bit 0 is the first bit on the line
  logic [7:0] rx_byte;
  assign rx_byte = rx_sh_reg >> (2'h3 - line_ctl_reg[1:0]);
  assign rx_in_valid = os_tick && (rx_state_reg == qup_pkg::QUP_RX_STOP) &&
                       (rx_os_reg == 4'h0) && rx_line;

  qup_fifo #(.WIDTH(8), .DEPTH(`QUP_FIFO_DEPTH), .AW(6)) u_rx_fifo (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .in_valid(rx_in_valid), .in_ready(rx_in_ready), .in_data(rx_byte),
    .out_valid(rx_out_valid), .out_ready(rx_out_ready), .out_data(rx_out_data),
    .level(rx_level));

  assign rx_out_ready = rd_pulse && (addr_reg == `QUP_ADDR_DATA);
  assign status_rd    = rd_pulse && (addr_reg == `QUP_ADDR_STATUS);

  // sticky error flags, set wins over the clear-on-read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_break_reg <= 1'b0;
      err_idle_reg  <= 1'b0;
      err_frame_reg <= 1'b0;
      err_over_reg  <= 1'b0;
      err_par_reg   <= 1'b0;
      err_under_reg <= 1'b0;
      idle_reg      <= 6'h0;
      tx_started_reg <= 1'b0;
    end else begin
      if (status_rd) begin
        err_break_reg <= 1'b0;
        err_idle_reg  <= 1'b0;
        err_frame_reg <= 1'b0;
        err_over_reg  <= 1'b0;
        err_par_reg   <= 1'b0;
        err_under_reg <= 1'b0;
      end
      if (tx_out_ready && tx_out_valid) tx_started_reg <= 1'b1;
      if (os_tick && rx_state_reg == qup_pkg::QUP_RX_STOP && rx_os_reg == 4'h0) begin
        if (!rx_line && rx_sh_reg == 8'h00) err_break_reg <= 1'b1;
        else if (!rx_line) err_frame_reg <= 1'b1;
        if (line_ctl_reg[`QUP_LCR_PAR_EN] && rx_par_reg) err_par_reg <= 1'b1;
      end
      if (rx_in_valid && !rx_in_ready) err_over_reg <= 1'b1;
      if (tx_out_ready && !tx_out_valid && tx_started_reg) begin
        err_under_reg  <= 1'b1;
        tx_started_reg <= 1'b0;
      end
      if (bit_tick) begin
        idle_reg <= (rx_line && rx_state_reg == qup_pkg::QUP_RX_IDLE) ?
                    ((idle_reg == 6'h3f) ? idle_reg : idle_reg + 6'h1) : 6'h0;
        if (idle_reg == 6'(`QUP_IDLE_CHARS * 10) && rx_level != 7'h0) err_idle_reg <= 1'b1;
      end
    end
  end

  // flow control and ready outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      request_to_send_n <= 1'b1;
    end else if (rx_level >= {flow_threshold_reg[3:0], 2'h0}) begin
      request_to_send_n <= 1'b1;
    end else if (rx_level <= {flow_threshold_reg[7:4], 2'h0}) begin
      request_to_send_n <= 1'b0;
    end
  end

  assign transmit_ready_flag = tx_in_ready;
  assign receive_ready_flag  = rx_out_valid;
  assign rx_threshold_irq    = rx_level >= {1'b0, flow_threshold_reg[7:4], 2'h0};
  assign tx_threshold_irq    = tx_level <= {1'b0, flow_threshold_reg[3:0], 2'h0};
  assign carrier_present     = !carrier_present_n_s;

  // read data held from the strobe edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_bus_out <= 8'h00;
    end else if (rd_pulse) begin
      case (addr_reg)
        `QUP_ADDR_DATA:      data_bus_out <= rx_out_data;
        `QUP_ADDR_LINE_CTL:  data_bus_out <= line_ctl_reg;
        `QUP_ADDR_DIV_LO:    data_bus_out <= divisor_reg[7:0];
        `QUP_ADDR_DIV_HI:    data_bus_out <= divisor_reg[15:8];
        `QUP_ADDR_MODEM_CTL: data_bus_out <= modem_control_reg;
        `QUP_ADDR_STATUS:    data_bus_out <= {carrier_present, err_under_reg, err_idle_reg,
                                              err_break_reg, err_frame_reg, err_par_reg,
                                              err_over_reg, rx_out_valid};
        `QUP_ADDR_FLOW_THR:  data_bus_out <= flow_threshold_reg;
        `QUP_ADDR_READY_SUM: data_bus_out <= {peer_receive_ready, rx_out_valid,
                                              peer_transmit_ready, tx_in_ready};
        default:             data_bus_out <= 8'h00;
      endcase
    end
  end

  assign data_bus_oe_n = rd_s | cs_s;
endmodule // qup_uart

// ===== test/qup_uart_chk.sv
// checker for the serial channel: relations between the top ports over time
// assumes a bind from the bench; one clock, asynchronous active-low reset
`timescale 1ns/10ps
module qup_uart_chk (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // register port
  input wire logic       channel_select_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic [7:0] data_bus_out,
  input wire logic       data_bus_oe_n,
  // line and status
  input wire logic       serial_out,
  input wire logic       carrier_detect_n,
  input wire logic       transmit_ready_flag,
  input wire logic       receive_ready_flag,
  input wire logic       carrier_present
);
  logic [7:0] rd_seen_reg;
  logic [7:0] wr_seen_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // recent selected read and write strobes, newest in bit 0
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rd_seen_reg <= 8'h00;
    else rd_seen_reg <= {rd_seen_reg[6:0], ~read_strobe_n & ~channel_select_n};
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) wr_seen_reg <= 8'h00;
    else wr_seen_reg <= {wr_seen_reg[6:0], ~write_strobe_n & ~channel_select_n};
  end
  reset_idle_a: assert property ($rose(rst_n) |-> serial_out && data_bus_oe_n && transmit_ready_flag)
    else $error("line or bus not idle after reset");
  carrier_on_a: assert property ((!carrier_detect_n) [*4] |-> carrier_present)
    else $error("carrier not shown while detect low");
  carrier_off_a: assert property (carrier_detect_n [*4] |-> !carrier_present)
    else $error("carrier shown while detect high");
  oe_cause_a: assert property (!data_bus_oe_n |-> !$past(read_strobe_n, 2) && !$past(channel_select_n, 2))
    else $error("bus driven without selected read");
  oe_drive_a: assert property ((!read_strobe_n && !channel_select_n) [*4] |-> !data_bus_oe_n)
    else $error("bus not driven during selected read");
  dout_hold_a: assert property ($changed(data_bus_out) |-> |rd_seen_reg)
    else $error("read data changed without a read");
  rx_pop_a: assert property ($fell(receive_ready_flag) |-> |rd_seen_reg)
    else $error("receive queue emptied without a read");
  tx_push_a: assert property ($fell(transmit_ready_flag) |-> |wr_seen_reg)
    else $error("transmit queue filled without a write");
endmodule // qup_uart_chk

// ===== test/qup_modem.sv
// modem model on the serial line: decodes frames from the channel, sends characters
// assumes the bench sets bit length in sys_clk cycles and the frame format
`timescale 1ns/10ps
module qup_modem (
  // clock
  input  wire logic       sys_clk,
  // serial line
  input  wire logic       serial_out,
  output logic            serial_in,
  // frame format
  input  wire logic [7:0] bit_len,
  input  wire logic [3:0] data_len,
  input  wire logic       par_en
);
  logic [7:0] got_byte;
  logic       got_par;
  logic       got_stop;
  int         got_count;
  int         k;
  initial begin
    serial_in = 1'b1;
    got_count = 0;
  end
  // sample each bit in its middle, least significant first
  always begin
    @(negedge serial_out);
    repeat (bit_len / 2) @(negedge sys_clk);
    got_byte = 8'h00;
    for (k = 0; k < data_len; k++) begin
      repeat (bit_len) @(negedge sys_clk);
      got_byte[k] = serial_out;
    end
    if (par_en) begin
      repeat (bit_len) @(negedge sys_clk);
      got_par = serial_out;
    end
    repeat (bit_len) @(negedge sys_clk);
    got_stop = serial_out;
    got_count++;
  end
  task send(input logic [7:0] val, input logic par);
    int j;
    serial_in = 1'b0;
    repeat (bit_len) @(negedge sys_clk);
    for (j = 0; j < data_len; j++) begin
      serial_in = val[j];
      repeat (bit_len) @(negedge sys_clk);
    end
    if (par_en) begin
      serial_in = par;
      repeat (bit_len) @(negedge sys_clk);
    end
    serial_in = 1'b1;
    repeat (bit_len * 2) @(negedge sys_clk);
  endtask
endmodule // qup_modem

// ===== test/test_quad_uart_clock_prescale_and_framing.sv
// self-checking bench for one serial channel with a modem model on its line
// assumes 10 MHz sys_clk; register port driven at falling edges
`timescale 1ns/10ps
module test_quad_uart_clock_prescale_and_framing;
  logic       sys_clk, rst_n, prescaler_select_input, channel_select_n, read_strobe_n;
  logic       write_strobe_n, data_bus_oe_n, serial_out, serial_in, carrier_detect_n;
  logic       request_to_send_n, transmit_ready_flag, receive_ready_flag, par_en;
  logic       rx_threshold_irq, tx_threshold_irq, carrier_present;
  logic [2:0] register_address, peer_transmit_ready, peer_receive_ready;
  logic [7:0] data_bus_in, data_bus_out, rd_val, b, lcr, bit_len;
  logic [3:0] data_len;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int         bad_count, checks_done, i, n;
  qup_uart uut (.sys_clk, .rst_n, .prescaler_select_input, .channel_select_n, .read_strobe_n,
    .write_strobe_n, .register_address, .data_bus_in, .data_bus_out, .data_bus_oe_n,
    .peer_transmit_ready, .peer_receive_ready, .serial_out, .serial_in, .carrier_detect_n,
    .request_to_send_n, .transmit_ready_flag, .receive_ready_flag, .rx_threshold_irq,
    .tx_threshold_irq, .carrier_present);
  qup_modem modem (.sys_clk, .serial_out, .serial_in, .bit_len, .data_len, .par_en);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    channel_select_n = 1'b0;
    write_strobe_n = 1'b0;
    register_address = a;
    data_bus_in = d;
    repeat (4) @(negedge sys_clk);
    write_strobe_n = 1'b1;
    channel_select_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  task rd(input logic [2:0] a);
    @(negedge sys_clk);
    channel_select_n = 1'b0;
    read_strobe_n = 1'b0;
    register_address = a;
    repeat (6) @(negedge sys_clk);
    rd_val = data_bus_out;
    read_strobe_n = 1'b1;
    channel_select_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  task tx_check(input logic [7:0] v);
    int n0;
    int k;
    n0 = modem.got_count;
    exp_q.push_back(v);
    wr(3'h0, v);
    for (k = 0; k < 2000 && modem.got_count == n0; k++) @(negedge sys_clk);
    chk(8'(modem.got_count - n0), 8'h01);
    chk(modem.got_byte, exp_q.pop_front());
    if (par_en) chk({7'h0, modem.got_par}, {7'h0, lcr[4] ? ^v : ~^v});
    chk({7'h0, modem.got_stop}, 8'h01);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    {rst_n, prescaler_select_input, register_address, data_bus_in} = '0;
    {channel_select_n, read_strobe_n, write_strobe_n, carrier_detect_n} = 4'hf;
    {peer_transmit_ready, peer_receive_ready, bad_count, checks_done} = '0;
    {bit_len, data_len, par_en, seed} = {8'h80, 4'h8, 1'b0, 32'h378a695b};
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(3'h4);
    chk(rd_val & 8'h80, 8'h80);
    rd(3'h6);
    chk(rd_val, 8'h84);
    rd(3'h1);
    chk(rd_val, 8'h03);
    seed = xs(seed);
    {peer_transmit_ready, peer_receive_ready} = seed[5:0];
    rd(3'h7);
    chk(rd_val, {peer_receive_ready, 1'b0, peer_transmit_ready, 1'b1});
    chk({5'h0, tx_threshold_irq, rx_threshold_irq, request_to_send_n}, 8'h04);
    carrier_detect_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk({7'h0, carrier_present}, 8'h01);
    rd(3'h5);
    chk(rd_val & 8'h80, 8'h80);
    wr(3'h2, 8'h02);
    for (i = 0; i < 4; i++) begin
      lcr = i[7:0] | (i < 3 ? 8'h08 : 8'h00) | (i[0] ? 8'h10 : 8'h00) | (i == 2 ? 8'h04 : 8'h00);
      {data_len, par_en} = {4'(5 + i), lcr[3]};
      wr(3'h1, lcr);
      seed = xs(seed);
      tx_check(seed[7:0] & (8'hff >> (3 - i)));
    end
    {lcr, data_len, par_en} = {8'h1b, 4'h8, 1'b1};
    wr(3'h1, lcr);
    seed = xs(seed);
    b = seed[7:0];
    modem.send(b, ^b);
    repeat (20) @(negedge sys_clk);
    rd(3'h0);
    chk(rd_val, b);
    modem.send(b, ~^b);
    repeat (20) @(negedge sys_clk);
    rd(3'h5);
    chk(rd_val & 8'h44, 8'h44);
    rd(3'h0);
    chk(rd_val, b);
    wr(3'h4, 8'h00);
    wr(3'h2, 8'h08);
    rd(3'h4);
    chk(rd_val & 8'h80, 8'h00);
    seed = xs(seed);
    tx_check(seed[7:0]);
    wr(3'h4, 8'h10);
    seed = xs(seed);
    wr(3'h0, seed[7:0]);
    for (n = 0; n < 2000 && receive_ready_flag !== 1'b1; n++) @(negedge sys_clk);
    chk({7'h0, receive_ready_flag}, 8'h01);
    rd(3'h0);
    chk(rd_val, seed[7:0]);
    wr(3'h4, 8'h00);
    wr(3'h2, 8'h00);
    for (n = 0; n < 70 && transmit_ready_flag === 1'b1; n++) wr(3'h0, n[7:0]);
    chk(n[7:0], 8'h40);
    chk({5'h0, tx_threshold_irq, rx_threshold_irq, request_to_send_n}, 8'h00);
    prescaler_select_input = 1'b1;
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(3'h4);
    chk(rd_val & 8'h80, 8'h00);
    chk({7'h0, transmit_ready_flag}, 8'h01);
    end_of_test();
  end
endmodule // test_quad_uart_clock_prescale_and_framing
bind qup_uart qup_uart_chk chk (.sys_clk, .rst_n, .channel_select_n, .read_strobe_n,
  .write_strobe_n, .data_bus_out, .data_bus_oe_n, .serial_out, .carrier_detect_n,
  .transmit_ready_flag, .receive_ready_flag, .carrier_present);
